//--- spc_clk_div.sv
// Master shift clock generator with edge pulses and end-of-burst pulse
module spc_clk_div #(
  parameter int HALF_W = 8,
  parameter int EDGE_W = 6
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              start_i,
  input  wire logic              stop_i,
  input  wire logic [HALF_W-1:0] half_i,
  input  wire logic [EDGE_W-1:0] edges_i,
  input  wire logic              idle_i,
  // Clock and edges out
  spc_edge_if.src                eif
);

  logic              run;
  logic [HALF_W-1:0] cnt;
  logic [EDGE_W-1:0] left;
  logic              sck;
  logic              rise;
  logic              fall;
  logic              done;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run  <= 1'b0;
      cnt  <= '0;
      left <= '0;
      sck  <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
      done <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      done <= 1'b0;
      if (stop_i) begin
        run <= 1'b0;
        sck <= idle_i;
      end else if (start_i) begin
        run  <= 1'b1;
        cnt  <= HALF_W'(1);
        left <= edges_i;
        sck  <= idle_i;
      end else if (run) begin
        if (cnt >= half_i) begin
          cnt  <= HALF_W'(1);
          sck  <= ~sck;
          rise <= ~sck;
          fall <= sck;
          left <= left - EDGE_W'(1);
          if (left == EDGE_W'(1)) begin
            run  <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          cnt <= cnt + HALF_W'(1);
        end
      end else begin
        sck <= idle_i;
      end
    end
  end

  assign eif.sck  = sck;
  assign eif.rise = rise;
  assign eif.fall = fall;
  assign eif.done = done;

endmodule

//--- spc_edge_det.sv
// Edge detector for the shift clock taken in from the link
module spc_edge_det (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Sampled clock level
  input  wire logic level_i,
  // Edges out
  spc_edge_if.src   eif
);

  logic prev;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign eif.sck  = level_i;
  assign eif.rise = level_i & ~prev;
  assign eif.fall = ~level_i & prev;
  assign eif.done = 1'b0;

endmodule

//--- spc_edge_if.sv
// Shift clock level and edge pulses passed from a clock source to the core
interface spc_edge_if;
  logic sck;
  logic rise;
  logic fall;
  logic done;
  modport src (output sck, output rise, output fall, output done);
  modport dst (input sck, input rise, input fall, input done);
endinterface

//--- spc_far_slave.sv
// Far-end serial slave that answers the port's shift clock in normal mode
module spc_far_slave (
  // Word load
  input  wire logic        load_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] tx_i,
  // Serial lines
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic [15:0]      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;

  // Launch on falling edges, sample on rising edges
  always @(posedge load_i or negedge sck_i) begin
    if (load_i) begin
      sh <= tx_i;
    end else begin
      sh <= {sh[14:0], 1'b0};
    end
  end
  assign miso_o = wide_i ? sh[15] : sh[7];
  always @(posedge sck_i) begin
    rx_o <= {rx_o[14:0], mosi_i};
  end
endmodule

//--- spc_pkg.sv
// Constants, field positions and types shared by the shift port files
package spc_pkg;

  // Bus geometry
  localparam int unsigned SPC_ADR_W = 5;
  localparam int unsigned SPC_DAT_W = 32;
  localparam int unsigned SPC_REG_W = 16;

  // Register indices and byte addresses (byte address = 4 * index)
  localparam int unsigned SPC_DATA_IDX = 0;
  localparam int unsigned SPC_CTRL_IDX = 2;
  localparam int unsigned SPC_STAT_IDX = 4;
  localparam logic [SPC_ADR_W-1:0] SPC_DATA_ADDR = SPC_ADR_W'(SPC_DATA_IDX * 4);
  localparam logic [SPC_ADR_W-1:0] SPC_CTRL_ADDR = SPC_ADR_W'(SPC_CTRL_IDX * 4);
  localparam logic [SPC_ADR_W-1:0] SPC_STAT_ADDR = SPC_ADR_W'(SPC_STAT_IDX * 4);

  // Control register fields
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_ROLE   = 1;
  localparam int unsigned CTRL_WIDTH  = 2;
  localparam int unsigned CTRL_ECHO   = 3;
  localparam int unsigned CTRL_EIO    = 4;
  localparam int unsigned CTRL_EIR    = 5;
  localparam int unsigned CTRL_EIW    = 6;
  localparam int unsigned CTRL_EDGE   = 7;
  localparam int unsigned CTRL_IDLE   = 8;
  localparam int unsigned CTRL_DIV_LO = 9;
  localparam int unsigned CTRL_DIV_HI = 15;
  localparam logic [SPC_REG_W-1:0] SPC_CTRL_RST = 16'h0000;

  // Status register fields
  localparam int unsigned STAT_BSY = 0;
  localparam int unsigned STAT_RBF = 1;
  localparam int unsigned STAT_OVR = 2;

  // Word sizes and divider geometry
  localparam int unsigned SPC_CNT_W  = 5;
  localparam int unsigned SPC_EDGE_W = 6;
  localparam int unsigned SPC_HALF_W = 8;
  localparam logic [SPC_CNT_W-1:0] SPC_BITS_8  = 5'h08;
  localparam logic [SPC_CNT_W-1:0] SPC_BITS_16 = 5'h10;
  localparam logic SPC_KNOWN_LEVEL = 1'b0;

  // Transfer state
  typedef enum logic [1:0] {
    SPC_IDLE,
    SPC_RUN,
    SPC_HOLD
  } spc_state_t;

  // Byte-lane merge of a 16-bit register
  function automatic logic [SPC_REG_W-1:0] spc_merge(input logic [SPC_REG_W-1:0] old_v,
                                                     input logic [SPC_REG_W-1:0] new_v,
                                                     input logic [1:0]           sel);
    spc_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

endpackage

//--- spc_shift_port.sv
// Shift port: registers, transfer control, status flags and pin steering
// Functional notes
// - Reset clears all control bits
// - Enable written low clears busy, full, overrun
// - Disabled pins: idle clock, inputs, fixed level; here clock and master-out slave-in pins stay driven while role bit is 1
// - Role bit: 0 slave, 1 master
// - Width bit: 0 eight, 1 sixteen bits
// - Slave echo resends input when data invalid
// - Data valid from write until transfer end
// - Overrun enable raises interrupt on overrun
// - Read enable raises interrupt on buffer full
// - Write enable raises interrupt when not busy
// - Edge bit selects launch and sample edges
// - Idle bit sets shift clock rest level
// - Master clock divides system clock by 2 * (divider + 1)
// - Master busy sets on data write
// - Slave busy sets on write or leading edge
// - Busy clears only once word reaches buffer
// - Completion loads empty buffer, sets full flag
// - Data read clears full or reloads pending word
// - Master overrun when starting with both full
// - Overrun clears by writing one only
// - Eight-bit mode shifts low byte, MSB first
// - Master gives eight or sixteen clocks then idles
// - Slave drives output only while selected
// - Eight-bit completion loads low buffer byte only
//
// Chosen here: the register addresses and register access over Wishbone.
module spc_shift_port
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [SPC_ADR_W-1:0] adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [SPC_DAT_W-1:0] dat_i,
  output logic      [SPC_DAT_W-1:0] dat_o,
  output logic                      ack_o,
  // Shift clock pin
  input  wire logic                 shift_clock_i,
  output logic                      shift_clock_o,
  output logic                      shift_clock_oe_o,
  // Slave select pin
  input  wire logic                 slave_select_n_i,
  // Master-in slave-out pin
  input  wire logic                 master_in_slave_out_i,
  output logic                      master_in_slave_out_o,
  output logic                      master_in_slave_out_oe_o,
  // Master-out slave-in pin
  input  wire logic                 master_out_slave_in_i,
  output logic                      master_out_slave_in_o,
  output logic                      master_out_slave_in_oe_o,
  // Interrupt request
  output logic                      irq_o
);

  logic [SPC_REG_W-1:0]   shift_port_control;
  logic [SPC_REG_W-1:0]   shifter;
  logic [SPC_REG_W-1:0]   next_shifter;
  logic [SPC_REG_W-1:0]   rbuf;
  logic [SPC_REG_W-1:0]   wr_word;
  logic [SPC_CNT_W-1:0]   bit_cnt;
  logic [SPC_CNT_W-1:0]   nbits;
  logic [SPC_HALF_W-1:0]  half;
  logic                   tx_valid;
  logic                   read_buffer_full_flag;
  logic                   overrun_flag;
  logic                   busy;
  logic                   dout;
  logic                   last_in;
  spc_state_t             state;

  logic                   port_enable;
  logic                   role_select;
  logic                   width_select;
  logic                   echo_enable;
  logic                   overrun_irq_enable;
  logic                   read_irq_enable;
  logic                   write_irq_enable;
  logic                   clock_edge_select;
  logic                   clock_idle_level;
  logic [6:0]             clock_divider_field;

  logic                   req;
  logic                   fire;
  logic                   wr_data;
  logic                   rd_data;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   start_m;
  logic                   slave_act;
  logic                   rise_p;
  logic                   fall_p;
  logic                   sample_p;
  logic                   launch_p;
  logic                   lead_p;
  logic                   done_p;
  logic                   din;
  logic                   rb_from_shift;
  logic                   rb_from_hold;

  spc_edge_if m_if ();
  spc_edge_if s_if ();

  // Control fields
  assign port_enable         = shift_port_control[CTRL_EN];
  assign role_select         = shift_port_control[CTRL_ROLE];
  assign width_select        = shift_port_control[CTRL_WIDTH];
  assign echo_enable         = shift_port_control[CTRL_ECHO];
  assign overrun_irq_enable  = shift_port_control[CTRL_EIO];
  assign read_irq_enable     = shift_port_control[CTRL_EIR];
  assign write_irq_enable    = shift_port_control[CTRL_EIW];
  assign clock_edge_select   = shift_port_control[CTRL_EDGE];
  assign clock_idle_level    = shift_port_control[CTRL_IDLE];
  assign clock_divider_field = shift_port_control[CTRL_DIV_HI:CTRL_DIV_LO];

  // Bus decode
  assign req     = cyc_i & stb_i;
  assign fire    = req & ack_o;
  assign wr_data = fire & we_i & (adr_i == SPC_DATA_ADDR);
  assign rd_data = fire & ~we_i & (adr_i == SPC_DATA_ADDR);
  assign wr_ctrl = fire & we_i & (adr_i == SPC_CTRL_ADDR);
  assign wr_stat = fire & we_i & (adr_i == SPC_STAT_ADDR);
  assign wr_word = spc_merge(shifter, dat_i[SPC_REG_W-1:0], sel_i[1:0]);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req & ~ack_o) begin
      unique case (adr_i)
        SPC_DATA_ADDR: dat_o <= {16'h0000, rbuf};
        SPC_CTRL_ADDR: dat_o <= {16'h0000, shift_port_control};
        SPC_STAT_ADDR: dat_o <= {29'h00000000, overrun_flag, read_buffer_full_flag, busy};
        default:       dat_o <= '0;
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_port_control <= SPC_CTRL_RST;
    end else if (wr_ctrl) begin
      shift_port_control <= spc_merge(shift_port_control, dat_i[SPC_REG_W-1:0], sel_i[1:0]);
    end
  end

  // Word size and clock divider
  assign nbits = width_select ? SPC_BITS_16 : SPC_BITS_8;
  assign half  = {1'b0, clock_divider_field} + SPC_HALF_W'(1);

  // Master clock source and slave clock edges
  assign start_m = wr_data & port_enable & role_select & (state != SPC_RUN);

  spc_clk_div #(
    .HALF_W (SPC_HALF_W),
    .EDGE_W (SPC_EDGE_W)
  ) u_clk_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_m),
    .stop_i  (~port_enable | ~role_select),
    .half_i  (half),
    .edges_i ({nbits, 1'b0}),
    .idle_i  (clock_idle_level),
    .eif     (m_if)
  );

  spc_edge_det u_edge_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (shift_clock_i),
    .eif     (s_if)
  );

  // Edge roles
  assign slave_act = port_enable & ~role_select & ~slave_select_n_i;
  assign rise_p    = role_select ? (port_enable & m_if.rise) : (slave_act & s_if.rise);
  assign fall_p    = role_select ? (port_enable & m_if.fall) : (slave_act & s_if.fall);
  assign sample_p  = clock_edge_select ? fall_p : rise_p;
  assign launch_p  = clock_edge_select ? rise_p : fall_p;
  assign lead_p    = clock_idle_level ? fall_p : rise_p;
  assign din       = role_select ? master_in_slave_out_i : master_out_slave_in_i;
  assign done_p    = role_select ? (port_enable & m_if.done)
                                 : (sample_p & (bit_cnt == nbits - SPC_CNT_W'(1)));

  // Shifter after this cycle's sample
  always_comb begin
    next_shifter = shifter;
    if (sample_p) begin
      if (width_select) begin
        next_shifter = {shifter[14:0], din};
      end else begin
        next_shifter[7:0] = {shifter[6:0], din};
      end
    end
  end

  // Shifter and bit count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shifter <= '0;
      bit_cnt <= '0;
      last_in <= 1'b0;
    end else if (wr_data) begin
      shifter <= wr_word;
      bit_cnt <= '0;
    end else if (!port_enable || (!role_select && slave_select_n_i)) begin
      bit_cnt <= '0;
    end else if (done_p) begin
      shifter <= next_shifter;
      bit_cnt <= '0;
      last_in <= din;
    end else if (sample_p) begin
      shifter <= next_shifter;
      bit_cnt <= bit_cnt + SPC_CNT_W'(1);
      last_in <= din;
    end
  end

  // Transmit data validity
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid <= 1'b0;
    end else if (!port_enable) begin
      tx_valid <= 1'b0;
    end else if (wr_data) begin
      tx_valid <= 1'b1;
    end else if (done_p) begin
      tx_valid <= 1'b0;
    end
  end

  // Serial output bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout <= SPC_KNOWN_LEVEL;
    end else if (!port_enable) begin
      dout <= SPC_KNOWN_LEVEL;
    end else if (wr_data) begin
      dout <= width_select ? wr_word[15] : wr_word[7];
    end else if (launch_p) begin
      if (!role_select && echo_enable && !tx_valid) begin
        dout <= last_in;
      end else begin
        dout <= width_select ? shifter[15] : shifter[7];
      end
    end
  end

  // Transfer state
  assign rb_from_shift = done_p & (~read_buffer_full_flag | rd_data);
  assign rb_from_hold  = rd_data & (state == SPC_HOLD);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SPC_IDLE;
    end else if (!port_enable) begin
      state <= SPC_IDLE;
    end else begin
      unique case (state)
        SPC_IDLE: begin
          if (wr_data) begin
            state <= SPC_RUN;
          end else if (!role_select && lead_p) begin
            state <= SPC_RUN;
          end
        end
        SPC_RUN: begin
          if (done_p) begin
            state <= rb_from_shift ? SPC_IDLE : SPC_HOLD;
          end
        end
        SPC_HOLD: begin
          if (start_m) begin
            state <= SPC_RUN;
          end else if (rb_from_hold) begin
            state <= SPC_IDLE;
          end
        end
      endcase
    end
  end

  assign busy = (state != SPC_IDLE);

  // Read buffer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rbuf <= '0;
    end else if (rb_from_shift) begin
      if (width_select) begin
        rbuf <= next_shifter;
      end else begin
        rbuf[7:0] <= next_shifter[7:0];
      end
    end else if (rb_from_hold) begin
      if (width_select) begin
        rbuf <= shifter;
      end else begin
        rbuf[7:0] <= shifter[7:0];
      end
    end
  end

  // Read buffer full flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_buffer_full_flag <= 1'b0;
    end else if (!port_enable) begin
      read_buffer_full_flag <= 1'b0;
    end else if (rb_from_shift || rb_from_hold) begin
      read_buffer_full_flag <= 1'b1;
    end else if (rd_data) begin
      read_buffer_full_flag <= 1'b0;
    end
  end

  // Overrun flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_flag <= 1'b0;
    end else if (!port_enable) begin
      overrun_flag <= 1'b0;
    end else if (start_m && read_buffer_full_flag && (state == SPC_HOLD)) begin
      overrun_flag <= 1'b1;
    end else if (wr_stat && sel_i[0] && dat_i[STAT_OVR]) begin
      overrun_flag <= 1'b0;
    end
  end

  // Pin steering
  always_comb begin
    shift_clock_o            = (role_select & port_enable) ? m_if.sck : clock_idle_level;
    shift_clock_oe_o         = role_select;
    master_out_slave_in_o    = role_select ? dout : SPC_KNOWN_LEVEL;
    master_out_slave_in_oe_o = role_select;
    master_in_slave_out_o    = dout;
    master_in_slave_out_oe_o = slave_act;
  end

  // Interrupt request
  assign irq_o = (overrun_flag & overrun_irq_enable)
               | (read_buffer_full_flag & read_irq_enable)
               | (~busy & write_irq_enable);

endmodule

//--- spc_shift_port_props.sv
// Concurrent checks on the shift port's pins and register bus
module spc_shift_port_props
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Register bus
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [SPC_ADR_W-1:0] adr_i,
  input wire logic [3:0]           sel_i,
  input wire logic [SPC_DAT_W-1:0] dat_i,
  input wire logic [SPC_DAT_W-1:0] dat_o,
  input wire logic                 ack_o,
  // Serial pins
  input wire logic                 shift_clock_i,
  input wire logic                 shift_clock_o,
  input wire logic                 shift_clock_oe_o,
  input wire logic                 slave_select_n_i,
  input wire logic                 master_in_slave_out_i,
  input wire logic                 master_in_slave_out_o,
  input wire logic                 master_in_slave_out_oe_o,
  input wire logic                 master_out_slave_in_i,
  input wire logic                 master_out_slave_in_o,
  input wire logic                 master_out_slave_in_oe_o,
  input wire logic                 irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SPC_REG_W-1:0] ctrl_m;
  logic                 req;

  assign req = cyc_i && stb_i && !ack_o;

  // Shadow of the control register, updated at the ack edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_m <= SPC_CTRL_RST;
    end else if (cyc_i && stb_i && we_i && ack_o && adr_i == SPC_CTRL_ADDR) begin
      ctrl_m <= {sel_i[1] ? dat_i[15:8] : ctrl_m[15:8], sel_i[0] ? dat_i[7:0] : ctrl_m[7:0]};
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_answer: assert property (req |=> ack_o) else $error("ack missing");
  a_ctrl_readback: assert property (req && !we_i && adr_i == SPC_CTRL_ADDR |=>
    dat_o[15:0] == ctrl_m) else $error("control readback wrong");
  a_unmapped_zero: assert property (req && !we_i && adr_i != SPC_DATA_ADDR &&
    adr_i != SPC_CTRL_ADDR && adr_i != SPC_STAT_ADDR |=> dat_o == '0) else $error("unmapped read");
  a_clk_oe_role: assert property (shift_clock_oe_o == ctrl_m[CTRL_ROLE])
    else $error("clock direction wrong");
  a_mosi_oe_role: assert property (master_out_slave_in_oe_o == ctrl_m[CTRL_ROLE])
    else $error("data out direction wrong");
  a_miso_oe_sel: assert property (master_in_slave_out_oe_o ==
    (ctrl_m[CTRL_EN] && !ctrl_m[CTRL_ROLE] && !slave_select_n_i)) else $error("slave drive wrong");
  a_idle_clock: assert property (!ctrl_m[CTRL_EN] |->
    shift_clock_o == ctrl_m[CTRL_IDLE]) else $error("idle clock level wrong");
  a_irq_gate: assert property (irq_o |->
    (ctrl_m[CTRL_EIO] || ctrl_m[CTRL_EIR] || ctrl_m[CTRL_EIW])) else $error("irq without enable");
  a_sck_starts: assert property (ack_o && we_i && adr_i == SPC_DATA_ADDR &&
    ctrl_m[CTRL_EN] && ctrl_m[CTRL_ROLE] |-> ##[1:130] $changed(shift_clock_o))
    else $error("shift clock did not start");
endmodule

bind spc_shift_port spc_shift_port_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .shift_clock_i, .shift_clock_o, .shift_clock_oe_o,
  .slave_select_n_i, .master_in_slave_out_i, .master_in_slave_out_o, .master_in_slave_out_oe_o,
  .master_out_slave_in_i, .master_out_slave_in_o, .master_out_slave_in_oe_o, .irq_o);

//--- spc_shift_port_tb.sv
// Self-checking bench for the shift port
module spc_shift_port_tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic we; logic [SPC_ADR_W-1:0] adr; logic [15:0] wd; logic [15:0] ex;} spc_row_t;
  logic                 clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [SPC_ADR_W-1:0] adr_i;
  logic [3:0]           sel_i;
  logic [SPC_DAT_W-1:0] dat_i, dat_o;
  logic                 sck_o, sck_oe, miso_o, miso_oe, mosi_o, mosi_oe, far_miso, far_load;
  logic                 sck_d, sel_n, mosi_d;
  logic [15:0]          rd, cur, far_tx, far_rx;
  int                   failures, tests_run;
  wire sck_w  = sck_oe ? sck_o : sck_d;
  wire mosi_w = mosi_oe ? mosi_o : mosi_d;
  localparam logic [7:0] SLV_PAT = 8'hA6;
  wire miso_w = miso_oe ? miso_o : far_miso;
  spc_row_t rows [9] = '{
    '{1'b0, SPC_CTRL_ADDR, 16'h0000, 16'h0000}, '{1'b0, SPC_STAT_ADDR, 16'h0000, 16'h0000},
    '{1'b1, SPC_CTRL_ADDR, 16'hFFFE, 16'h0000}, '{1'b0, SPC_CTRL_ADDR, 16'h0000, 16'hFFFE},
    '{1'b1, SPC_CTRL_ADDR, 16'h0000, 16'h0000}, '{1'b1, 5'h0C, 16'hFFFF, 16'h0000},
    '{1'b0, 5'h0C, 16'h0000, 16'h0000}, '{1'b1, SPC_STAT_ADDR, 16'h0007, 16'h0000},
    '{1'b0, SPC_STAT_ADDR, 16'h0000, 16'h0000}};

  spc_shift_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .shift_clock_i(sck_w), .shift_clock_o(sck_o), .shift_clock_oe_o(sck_oe),
    .slave_select_n_i(sel_n), .master_in_slave_out_i(miso_w), .master_in_slave_out_o(miso_o),
    .master_in_slave_out_oe_o(miso_oe), .master_out_slave_in_i(mosi_w),
    .master_out_slave_in_o(mosi_o), .master_out_slave_in_oe_o(mosi_oe), .irq_o(irq_o));
  spc_far_slave i_far (.load_i(far_load), .wide_i(cur[CTRL_WIDTH]), .tx_i(far_tx), .sck_i(sck_w),
    .mosi_i(mosi_w), .miso_o(far_miso), .rx_o(far_rx));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wb(input logic w, input logic [SPC_ADR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    chk_bit(ack_o, 1'b1);
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic setc(input logic [15:0] c);
    wb(1'b1, SPC_CTRL_ADDR, cur & 16'hFFFE);
    wb(1'b1, SPC_CTRL_ADDR, c & 16'hFFFE);
    wb(1'b1, SPC_CTRL_ADDR, c);
    cur = c;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, SPC_STAT_ADDR, 16'h0000);
      n++;
    end while (rd[STAT_BSY] !== 1'b0 && n < 100);
  endtask

  task automatic xfer(input logic [15:0] c, input logic [15:0] tx, input logic [15:0] ptx,
                      input logic [15:0] exp_buf);
    logic [15:0] m;
    setc(c);
    m = c[CTRL_WIDTH] ? 16'hFFFF : 16'h00FF;
    far_tx <= ptx;
    far_load <= 1'b1;
    @(posedge clk_i);
    far_load <= 1'b0;
    wb(1'b1, SPC_DATA_ADDR, tx);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0001);
    wait_idle();
    chk_word(rd, 16'h0002);
    chk_word(far_rx & m, tx & m);
    chk_bit(irq_o, c[CTRL_EIR]);
    wb(1'b0, SPC_DATA_ADDR, 16'h0000);
    chk_word(rd, exp_buf);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0000);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    failures++;
    close_out();
  end

  initial begin
    {cyc_i, stb_i, we_i, far_load, mosi_d} = '0;
    {sck_d, sel_n} = 2'h3;
    adr_i = '0;
    dat_i = '0;
    sel_i = 4'hF;
    far_tx = '0;
    cur = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we) chk_word(rd, rows[i].ex);
    end
    xfer(16'h0207, 16'h5AC3, 16'hC35A, 16'hC35A);
    xfer(16'h0223, 16'h003C, 16'h00A5, 16'hC3A5);
    setc(16'h0213);
    wb(1'b1, SPC_DATA_ADDR, 16'h0011);
    wait_idle();
    wb(1'b1, SPC_DATA_ADDR, 16'h0022);
    repeat (60) @(posedge clk_i);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0003);
    wb(1'b1, SPC_DATA_ADDR, 16'h0033);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0007);
    chk_bit(irq_o, 1'b1);
    wb(1'b1, SPC_STAT_ADDR, 16'h0004);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0003);
    wb(1'b1, SPC_CTRL_ADDR, 16'h0212);
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0000);
    // Slave role, echo, alternate edges, clock idle high
    setc(16'h01C9);
    sel_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_d <= SLV_PAT[i];
      repeat (3) @(posedge clk_i);
      sck_d <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (i == 7) begin
        wb(1'b0, SPC_STAT_ADDR, 16'h0000);
        chk_word(rd, 16'h0001);
      end
      sck_d <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk_bit(miso_o, SLV_PAT[i]);
    end
    sel_n <= 1'b1;
    wb(1'b0, SPC_STAT_ADDR, 16'h0000);
    chk_word(rd, 16'h0002);
    chk_bit(irq_o, 1'b1);
    wb(1'b0, SPC_DATA_ADDR, 16'h0000);
    chk_word(rd, 16'hC3A6);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    cur = '0;
    wb(1'b0, SPC_CTRL_ADDR, 16'h0000);
    chk_word(rd, 16'h0000);
    close_out();
  end
endmodule
